// ---- core/hbp_host_port.sv ----
`default_nettype none
module hbp_host_port
    import hbp_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire hbp_pins_s             host_pins,
    output var  logic [7:0]            data_out,
    output var  logic                  data_oe,
    output var  logic                  int_n,
    output var  logic [NUM_AXES-1:0]   axis_ref_tick,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr
);
    logic [$bits(hbp_pins_s)-1:0] sp_raw;
    hbp_pins_s                    sp;

    hbp_sync #(
        .W       ($bits(hbp_pins_s)),
        .RST_VAL (PINS_IDLE)
    ) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (host_pins),
        .q       (sp_raw)
    );
    assign sp = sp_raw;

    logic host_cs;
    logic acc_wr;
    logic acc_rd;

    always_comb begin
        host_cs = !sp.cs_n;
        if (sp.if_format_strap) begin
            // Combined strobe, pin two gives direction
            acc_wr = host_cs && !sp.strobe_pin_n && !sp.dir_rd_pin;
            acc_rd = host_cs && !sp.strobe_pin_n && sp.dir_rd_pin;
        end else begin
            acc_wr = host_cs && !sp.strobe_pin_n;
            acc_rd = host_cs && !sp.dir_rd_pin;
        end
    end

    // APB handshake terms
    logic apb_fire;
    logic apb_wr;
    logic apb_rd;
    logic core_clr_in;
    logic core_set_out;

    assign apb_fire     = psel && penable && pready;
    assign apb_wr       = apb_fire && pwrite;
    assign apb_rd       = apb_fire && !pwrite;
    assign core_clr_in  = apb_rd && (paddr == OFF_IN_DATA);
    assign core_set_out = apb_wr && (paddr == OFF_OUT_DATA);

    // Host port state
    logic            acc_wr_q, next_acc_wr_q;
    logic            acc_rd_q, next_acc_rd_q;
    logic            wr_sel_q, next_wr_sel_q;
    logic            rd_sel_q, next_rd_sel_q;
    logic [7:0]      wr_byte_q, next_wr_byte_q;
    logic [7:0]      in_byte, next_in_byte;
    logic            in_full, next_in_full;
    logic            in_is_cmd, next_in_is_cmd;
    logic [7:0]      out_byte, next_out_byte;
    logic            out_full, next_out_full;
    hbp_state_e      state, next_state;
    logic [7:0]      next_data_out;
    logic            next_data_oe;
    logic [HSTAT_W-1:0] hstat;
    logic            wr_end;
    logic            rd_start;
    logic            rd_end;
    logic [7:0]      rd_byte;

    assign wr_end   = acc_wr_q && !acc_wr;
    assign rd_start = acc_rd && !acc_rd_q;
    assign rd_end   = acc_rd_q && !acc_rd;
    assign rd_byte  = sp.reg_sel ? {hstat, out_full, in_full} : out_byte;

    always_comb begin
        next_acc_wr_q  = acc_wr;
        next_acc_rd_q  = acc_rd;
        // Byte and select sampled each cycle while strobe is low, held after, used at its end
        next_wr_sel_q  = acc_wr ? sp.reg_sel : wr_sel_q;
        next_wr_byte_q = acc_wr ? sp.data_in : wr_byte_q;
        next_rd_sel_q  = rd_start ? sp.reg_sel : rd_sel_q;
        next_in_byte   = wr_end ? wr_byte_q : in_byte;
        next_in_is_cmd = wr_end ? (wr_sel_q == SEL_CMD) : in_is_cmd;
        // Host write wins over a core clear in the same cycle
        next_in_full   = wr_end || (in_full && !core_clr_in);
        next_out_byte  = core_set_out ? pwdata[7:0] : out_byte;
        // Core load wins over the host draining the byte
        next_out_full  = core_set_out ||
                         (out_full && !(rd_end && rd_sel_q != SEL_CMD));
        next_data_out  = rd_start ? rd_byte : data_out;
        next_data_oe   = acc_rd;
        next_state     = state;
        unique case (state)
            HBP_IDLE: begin
                if (wr_end && wr_sel_q == SEL_CMD) begin
                    next_state = HBP_ACTIVE;
                end
            end
            HBP_ACTIVE: begin
                next_state = HBP_ACTIVE;
            end
            default: begin
                next_state = HBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_wr_q  <= 1'b0;
            acc_rd_q  <= 1'b0;
            wr_sel_q  <= 1'b0;
            rd_sel_q  <= 1'b0;
            wr_byte_q <= 8'h00;
            in_byte   <= 8'h00;
            in_full   <= 1'b0;
            in_is_cmd <= 1'b0;
            out_byte  <= 8'h00;
            out_full  <= 1'b0;
            state     <= HBP_IDLE;
            data_out  <= 8'h00;
            data_oe   <= 1'b0;
        end else begin
            acc_wr_q  <= next_acc_wr_q;
            acc_rd_q  <= next_acc_rd_q;
            wr_sel_q  <= next_wr_sel_q;
            rd_sel_q  <= next_rd_sel_q;
            wr_byte_q <= next_wr_byte_q;
            in_byte   <= next_in_byte;
            in_full   <= next_in_full;
            in_is_cmd <= next_in_is_cmd;
            out_byte  <= next_out_byte;
            out_full  <= next_out_full;
            state     <= next_state;
            data_out  <= next_data_out;
            data_oe   <= next_data_oe;
        end
    end

    // Interrupt causes: end per axis in low bits, error in high bits
    logic [NUM_CAUSES-1:0] pending, next_pending;
    logic [NUM_CAUSES-1:0] cause_set;
    logic [NUM_CAUSES-1:0] cause_clr;
    logic [NUM_CAUSES-1:0] en_mask;
    logic [HOLD_W-1:0]     hold, next_hold;
    logic                  next_int_n;
    logic                  cleared_now;
    logic [CTRL_W-1:0]     ctrl;

    always_comb begin
        cause_set = '0;
        cause_clr = '0;
        if (apb_wr && paddr == OFF_INT_CAUSE) begin
            cause_set = pwdata[CAUSE_SET_LSB +: NUM_CAUSES];
            cause_clr = pwdata[CAUSE_CLR_LSB +: NUM_CAUSES];
        end
        en_mask = {NUM_CAUSES{1'b1}};
        en_mask[CAUSE_ERR_LSB +: NUM_AXES] =
            {NUM_AXES{ctrl[CTRL_ERRINT_EN]}};
        next_pending = cause_set | (pending & ~cause_clr);
        cleared_now  = |(pending & ~next_pending);
        if (cleared_now && !int_n) begin
            next_hold = HOLD_W'(REARM_CYC);
        end else if (hold != '0) begin
            next_hold = hold - 1'b1;
        end else begin
            next_hold = hold;
        end
        next_int_n = !(|(next_pending & en_mask) && next_hold == '0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= '0;
            hold    <= '0;
            int_n   <= 1'b1;
        end else begin
            pending <= next_pending;
            hold    <= next_hold;
            int_n   <= next_int_n;
        end
    end

    // APB slave, one wait-free access cycle, registered answer
    logic [31:0]        next_prdata;
    logic               next_pready;
    logic               next_pslverr;
    logic [CTRL_W-1:0]  next_ctrl;
    logic [HSTAT_W-1:0] next_hstat;
    logic [ST_W-1:0]    status;

    always_comb begin
        status              = '0;
        status[ST_IN_FULL]  = in_full;
        status[ST_IN_CMD]   = in_is_cmd;
        status[ST_OUT_FULL] = out_full;
        status[ST_ACTIVE]   = (state == HBP_ACTIVE);
        status[ST_FORMAT]   = sp.if_format_strap;
        status[ST_INT]      = !int_n;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        next_pready  = psel && !penable;
        if (psel && !penable) begin
            unique case (paddr)
                OFF_CTRL:      next_prdata = {29'h0, ctrl};
                OFF_STATUS:    next_prdata = {26'h0, status};
                OFF_IN_DATA:   next_prdata = {24'h0, in_byte};
                OFF_OUT_DATA:  next_prdata = {24'h0, out_byte};
                OFF_HOST_STAT: next_prdata = {26'h0, hstat};
                OFF_INT_CAUSE: next_prdata = {28'h0, pending};
                default: begin
                    next_prdata  = 32'h0;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        next_ctrl  = (apb_wr && paddr == OFF_CTRL) ?
                     pwdata[CTRL_W-1:0] : ctrl;
        next_hstat = (apb_wr && paddr == OFF_HOST_STAT) ?
                     pwdata[HSTAT_W-1:0] : hstat;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            ctrl    <= CTRL_RESET;
            hstat   <= HSTAT_RESET;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            ctrl    <= next_ctrl;
            hstat   <= next_hstat;
        end
    end

    // Reference dividers; a pick change applies to the running count at once
    logic [NUM_AXES-1:0] pick;
    assign pick = {sp.axis2_refclk_pick, sp.axis1_refclk_pick};

    for (genvar a = 0; a < NUM_AXES; a++) begin : g_ref
        logic [DIV_W-1:0] cnt, next_cnt;
        logic [DIV_W-1:0] last;
        logic             next_tick;

        always_comb begin
            last = pick[a] ? DIV_W'(DIV_FAST - 1) :
                             DIV_W'(DIV_SLOW - 1);
            next_tick = 1'b0;
            next_cnt  = '0;
            if (ctrl[CTRL_SRC_LSB + a]) begin
                next_tick = (cnt >= last);
                next_cnt  = next_tick ? '0 : cnt + 1'b1;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt              <= '0;
                axis_ref_tick[a] <= 1'b0;
            end else begin
                cnt              <= next_cnt;
                axis_ref_tick[a] <= next_tick;
            end
        end
    end

    localparam int A_DIV_SLOW  = DIV_SLOW;
    localparam int A_REARM_GAP = REARM_CYC - 7;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rearm_start;
        !int_n && cleared_now && |(next_pending & en_mask);
    endsequence

    sequence s_rearm_wait;
        (int_n && hold != '0)[*8] ##A_REARM_GAP !int_n;
    endsequence

    a_idle_until_cmd: assert property (
        state == HBP_IDLE && !(wr_end && wr_sel_q == SEL_CMD)
        |=> state == HBP_IDLE)
        else $error("left idle without a host command");

    a_cs_gates_strobes: assert property (
        !host_cs ##1 !host_cs |=> !acc_wr_q && !acc_rd_q && !data_oe)
        else $error("strobe accepted while deselected");

    a_sel_routes_write: assert property (
        wr_end |=> in_full && in_is_cmd == ($past(wr_sel_q) == SEL_CMD)
                   && in_byte == $past(wr_byte_q))
        else $error("host write not routed by select");

    a_bus_release: assert property (
        !acc_rd |=> !data_oe)
        else $error("data bus driven outside a read");

    a_fmt_combined: assert property (
        host_cs && sp.if_format_strap && !sp.strobe_pin_n && sp.dir_rd_pin
        |=> data_oe && !acc_wr_q)
        else $error("combined strobe read not served");

    a_fmt_separate: assert property (
        host_cs && !sp.if_format_strap && !sp.strobe_pin_n
        && sp.dir_rd_pin |=> acc_wr_q && !data_oe)
        else $error("separate write strobe not served");

    a_ref_fast: assert property (
        axis_ref_tick[0] && pick[0] && ctrl[CTRL_SRC_LSB]
        && $stable(pick[0]) |-> ##80 axis_ref_tick[0])
        else $error("fast reference period wrong");

    a_ref_slow: assert property (
        axis_ref_tick[1] && !pick[1] && ctrl[CTRL_SRC_LSB + 1]
        |-> ##[A_DIV_SLOW:A_DIV_SLOW] axis_ref_tick[1])
        else $error("slow reference period wrong");

    a_int_cause: assert property (
        |(pending & en_mask) && hold == '0 && !apb_wr |=> !int_n)
        else $error("interrupt not raised for pending cause");

    a_int_rearm: assert property (
        s_rearm_start |=> s_rearm_wait)
        else $error("interrupt rearm gap wrong");

    a_rd_no_wait: assert property (
        rd_start |=> data_oe && data_out == $past(rd_byte))
        else $error("host read byte not presented");
endmodule : hbp_host_port
`default_nettype wire

// ---- pkg/hbp_pkg.sv ----
`default_nettype none
package hbp_pkg;
    // Pulse reference dividers follow the pclk rate
    localparam int unsigned SYS_CLK_KHZ  = 40000;
    localparam int unsigned REF_FAST_KHZ = 500;
    localparam int unsigned REF_SLOW_KHZ = 125;
    localparam int unsigned DIV_FAST     = SYS_CLK_KHZ / REF_FAST_KHZ;
    localparam int unsigned DIV_SLOW     = SYS_CLK_KHZ / REF_SLOW_KHZ;
    localparam int unsigned DIV_W        = $clog2(DIV_SLOW);

    localparam int unsigned REARM_US     = 5;
    localparam int unsigned REARM_CYC    =
        (REARM_US * SYS_CLK_KHZ + 999) / 1000;
    localparam int unsigned HOLD_W       = $clog2(REARM_CYC + 1);
    localparam int unsigned RESET_LOW_US = 2;

    localparam int unsigned NUM_AXES     = 2;
    localparam int unsigned NUM_CAUSES   = 4;
    localparam int unsigned APB_ADDR_W   = 8;

    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_IN_DATA   = 8'h08;
    localparam logic [7:0] OFF_OUT_DATA  = 8'h0C;
    localparam logic [7:0] OFF_HOST_STAT = 8'h10;
    localparam logic [7:0] OFF_INT_CAUSE = 8'h14;

    localparam int unsigned CTRL_W         = 3;
    localparam int unsigned CTRL_ERRINT_EN = 0;
    localparam int unsigned CTRL_SRC_LSB   = 1;
    localparam logic [2:0]  CTRL_RESET     = 3'h7;

    localparam int unsigned ST_W        = 6;
    localparam int unsigned ST_IN_FULL  = 0;
    localparam int unsigned ST_IN_CMD   = 1;
    localparam int unsigned ST_OUT_FULL = 2;
    localparam int unsigned ST_ACTIVE   = 3;
    localparam int unsigned ST_FORMAT   = 4;
    localparam int unsigned ST_INT      = 5;

    localparam int unsigned CAUSE_SET_LSB = 0;
    localparam int unsigned CAUSE_CLR_LSB = 4;
    localparam int unsigned CAUSE_END_LSB = 0;
    localparam int unsigned CAUSE_ERR_LSB = 2;

    localparam int unsigned HSTAT_W     = 6;
    localparam logic [5:0]  HSTAT_RESET = 6'h00;
    localparam logic        SEL_CMD     = 1'b1;

    typedef enum logic [1:0] {
        HBP_IDLE   = 2'b01,
        HBP_ACTIVE = 2'b10
    } hbp_state_e;

    typedef struct packed {
        logic       cs_n;
        logic       reg_sel;
        logic       strobe_pin_n;
        logic       dir_rd_pin;
        logic       if_format_strap;
        logic       axis1_refclk_pick;
        logic       axis2_refclk_pick;
        logic [7:0] data_in;
    } hbp_pins_s;

    localparam hbp_pins_s PINS_IDLE = '{
        cs_n: 1'b1, reg_sel: 1'b0, strobe_pin_n: 1'b1, dir_rd_pin: 1'b1,
        if_format_strap: 1'b0, axis1_refclk_pick: 1'b0,
        axis2_refclk_pick: 1'b0, data_in: 8'h00
    };
endpackage : hbp_pkg
`default_nettype wire

// ---- core/hbp_sync.sv ----
`default_nettype none
module hbp_sync #(
    parameter int unsigned   W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : hbp_sync
`default_nettype wire

// ---- tb/hbp_host_model.sv ----
`default_nettype none
module hbp_host_model
    import hbp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       fmt,
    input  wire logic       pick1,
    input  wire logic       pick2,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output var  hbp_pins_s  pins
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       cs_n  = 1'b1;
    logic       sel   = 1'b0;
    logic       wr_n  = 1'b1;
    logic       rd_n  = 1'b1;
    logic       drv   = 1'b0;
    logic [7:0] wbyte = 8'h00;
    logic [7:0] last  = 8'h00;
    logic [7:0] bus;
    logic       pin1;
    logic       pin2;

    // Released bus toggles so a stale byte never reads as valid
    assign bus = data_oe ? data_out : (drv ? wbyte : ~last);
    assign pin1 = fmt ? (wr_n & rd_n) : wr_n;
    assign pin2 = fmt ? wr_n : rd_n;

    always @(posedge pclk) last <= bus;

    always_comb begin
        pins = '{cs_n, sel, pin1, pin2, fmt, pick1, pick2, bus};
    end

    // No wait states: strobe width fixed, never stretched by the device
    task automatic host_wr(input logic cs, input logic s,
                           input logic [7:0] b);
        @(posedge pclk);
        cs_n  <= ~cs;
        sel   <= s;
        wbyte <= b;
        drv   <= 1'b1;
        @(posedge pclk);
        wr_n <= 1'b0;
        repeat (5) @(posedge pclk);
        wr_n <= 1'b1;
        repeat (2) @(posedge pclk);
        cs_n <= 1'b1;
        drv  <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : host_wr

    task automatic host_rd(input logic s, output logic [7:0] b,
                           output logic ok);
        int n;
        @(posedge pclk);
        cs_n <= 1'b0;
        sel  <= s;
        @(posedge pclk);
        rd_n <= 1'b0;
        n = 0;
        while (data_oe !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        ok = (n < 10);
        @(posedge pclk);
        b = bus;
        rd_n <= 1'b1;
        repeat (2) @(posedge pclk);
        cs_n <= 1'b1;
        n = 0;
        while (data_oe !== 1'b0 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        ok = ok & (n < 10);
        repeat (3) @(posedge pclk);
    endtask : host_rd
endmodule : hbp_host_model
`default_nettype wire

// ---- tb/hbp_host_port_tb.sv ----
`default_nettype none
module hbp_host_port_tb
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          pclk    = 1'b0;
    logic          presetn = 1'b0;
    logic          fmt     = 1'b1;
    logic          pick1   = 1'b1;
    logic          pick2   = 1'b0;
    logic          psel    = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite  = 1'b0;
    logic [7:0]    paddr   = 8'h00;
    logic [31:0]   pwdata  = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    hbp_pins_s     pins;
    logic [7:0]    data_out;
    logic          data_oe;
    logic          int_n;
    logic [1:0]    axis_ref_tick;
    int            errors   = 0;
    int            compares = 0;

    always #12.5 pclk = ~pclk;

    hbp_host_port i_dut (
        .pclk          (pclk),
        .presetn       (presetn),
        .host_pins     (pins),
        .data_out      (data_out),
        .data_oe       (data_oe),
        .int_n         (int_n),
        .axis_ref_tick (axis_ref_tick),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr)
    );

    hbp_host_model i_host (
        .pclk     (pclk),
        .fmt      (fmt),
        .pick1    (pick1),
        .pick2    (pick2),
        .data_out (data_out),
        .data_oe  (data_oe),
        .pins     (pins)
    );

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic fail_hang;
        errors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        wrap_up();
    endtask : fail_hang

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_hang();
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic apb_rd(input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask : apb_rd

    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : apb_wr

    task automatic hrd(input logic s, input logic [7:0] exp);
        logic [7:0] b;
        logic       ok;
        i_host.host_rd(s, b, ok);
        if (ok !== 1'b1) fail_hang();
        chk({24'h0, b}, {24'h0, exp});
    endtask : hrd

    task automatic tick_gap(input int ax, input int exp);
        int n;
        n = 0;
        while (axis_ref_tick[ax] !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) fail_hang();
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (axis_ref_tick[ax] !== 1'b1 && n < 400);
        chk(n, exp);
    endtask : tick_gap

    initial begin
        logic [31:0] st;
        int          n;
        for (int p = 0; p < 2; p++) begin
            presetn <= 1'b0;
            fmt     <= (p == 0);
            pick1   <= (p == 0);
            pick2   <= (p != 0);
            repeat (RESET_LOW_US * SYS_CLK_KHZ / 1000) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            st = {27'h0, fmt, 4'h0};
            apb_rd(OFF_CTRL, 32'h7, 1'b0);
            apb_rd(OFF_STATUS, st, 1'b0);
            i_host.host_wr(1'b0, 1'b0, 8'h11);
            apb_rd(OFF_STATUS, st, 1'b0);
            i_host.host_wr(1'b1, 1'b0, 8'h5A);
            chk({31'h0, data_oe}, 32'h0);
            apb_rd(OFF_STATUS, st | 32'h1, 1'b0);
            apb_rd(OFF_IN_DATA, 32'h5A, 1'b0);
            i_host.host_wr(1'b1, 1'b1, 8'hC3);
            apb_rd(OFF_STATUS, st | 32'hB, 1'b0);
            apb_rd(OFF_IN_DATA, 32'hC3, 1'b0);
            apb_wr(OFF_HOST_STAT, 32'h2B);
            apb_wr(OFF_OUT_DATA, 32'hA5);
            hrd(1'b1, 8'hAE);
            hrd(1'b0, 8'hA5);
            apb_rd(OFF_STATUS, st | 32'hA, 1'b0);
            tick_gap(0, SYS_CLK_KHZ / (fmt ? 500 : 125));
            tick_gap(1, SYS_CLK_KHZ / (fmt ? 125 : 500));
            $display("Host port pass %0d finished", p);
        end
        apb_rd(8'h18, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            apb_wr(OFF_INT_CAUSE, 32'h1 << i);
            repeat (3) @(posedge pclk);
            chk({31'h0, int_n}, 32'h0);
            apb_wr(OFF_INT_CAUSE, 32'h10 << i);
            repeat (3) @(posedge pclk);
            chk({31'h0, int_n}, 32'h1);
            // Clear starts the rearm hold; let it lapse before next cause
            repeat (REARM_CYC) @(posedge pclk);
        end
        // Error causes stay silent while their enable is off
        apb_wr(OFF_CTRL, 32'h6);
        apb_wr(OFF_INT_CAUSE, 32'h04);
        repeat (3) @(posedge pclk);
        chk({31'h0, int_n}, 32'h1);
        apb_wr(OFF_CTRL, 32'h7);
        repeat (3) @(posedge pclk);
        chk({31'h0, int_n}, 32'h0);
        apb_wr(OFF_INT_CAUSE, 32'h01);
        apb_rd(OFF_INT_CAUSE, 32'h5, 1'b0);
        apb_wr(OFF_INT_CAUSE, 32'h40);
        n = 0;
        while (int_n !== 1'b1 && n < 5) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (int_n === 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk(n, REARM_CYC);
        apb_wr(OFF_INT_CAUSE, 32'h10);
        repeat (250) @(posedge pclk);
        chk({31'h0, int_n}, 32'h1);
        apb_rd(OFF_INT_CAUSE, 32'h0, 1'b0);
        $display("Interrupt test finished");
        wrap_up();
    end
endmodule : hbp_host_port_tb
`default_nettype wire
